// ==== ub_pkg.sv ====
package ub_pkg;
	// Clock and link timing
	localparam int CLK_HZ = 40000000;
	localparam int BAUD_RST = 9600;
	localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_RST);
	localparam int I2C_HZ = 375000;
	localparam int I2C_QTR = (CLK_HZ + 4 * I2C_HZ - 1) / (4 * I2C_HZ);
	localparam int TIMEOUT_MS = 655;
	localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
	localparam int BUF_DEPTH = 256;
	// Command codes
	localparam logic [7:0] CMD_START = 8'h53;
	localparam logic [7:0] CMD_STOP = 8'h50;
	localparam logic [7:0] CMD_RREG = 8'h52;
	localparam logic [7:0] CMD_WREG = 8'h57;
	localparam logic [7:0] CMD_GPIN = 8'h49;
	localparam logic [7:0] CMD_GPOUT = 8'h4f;
	localparam logic [7:0] CMD_SLEEP = 8'h5a;
	localparam logic [7:0] SLEEP_KEY1 = 8'h5a;
	localparam logic [7:0] SLEEP_KEY2 = 8'ha5;
	localparam logic [7:0] HELLO0 = 8'h4f;
	localparam logic [7:0] HELLO1 = 8'h4b;
	// Internal register indices
	localparam logic [7:0] REG_BAUD_DIVIDER_LO = 8'h00;
	localparam logic [7:0] REG_BAUD_DIVIDER_HI = 8'h01;
	localparam logic [7:0] REG_PORTCFG1 = 8'h02;
	localparam logic [7:0] REG_PORTCFG2 = 8'h03;
	localparam logic [7:0] REG_IOSTATE = 8'h04;
	localparam logic [7:0] REG_RSVD = 8'h05;
	localparam logic [7:0] REG_OWNADR = 8'h06;
	localparam logic [7:0] REG_CLKLO = 8'h07;
	localparam logic [7:0] REG_CLKHI = 8'h08;
	localparam logic [7:0] REG_TOUT = 8'h09;
	localparam logic [7:0] REG_STAT = 8'h0a;
	localparam int REG_NUM = 11;
	// Reset values
	localparam logic [7:0] RST_PORTCFG = 8'h55;
	localparam logic [7:0] RST_OWNADR = 8'h26;
	localparam logic [7:0] RST_CLKLO = 8'h13;
	localparam logic [7:0] RST_CLKHI = 8'h00;
	localparam logic [7:0] RST_TOUT = 8'h66;
	localparam logic [3:0] STAT_HI = 4'hf;
	// Transfer status codes
	localparam logic [3:0] STAT_OK = 4'h0;
	localparam logic [3:0] STAT_NACK_ADR = 4'h1;
	localparam logic [3:0] STAT_NACK_DATA = 4'h2;
	localparam logic [3:0] STAT_ARB = 4'h3;
endpackage : ub_pkg

// ==== ub_if.sv ====
`timescale 1ns/1ps
interface ub_if;
	logic h2d;
	logic d2h;
	logic scl_o;
	logic scl_oe;
	logic sda_o;
	logic sda_oe;
	logic tgt_scl_oe;
	logic tgt_sda_oe;
	logic scl;
	logic sda;
	// Open-drain wired-AND with pull-up
	assign scl = ~((scl_oe & ~scl_o) | tgt_scl_oe);
	assign sda = ~((sda_oe & ~sda_o) | tgt_sda_oe);
	modport dev (input h2d, input scl, input sda, output d2h, output scl_o, output scl_oe, output sda_o, output sda_oe);
	modport host (output h2d, input d2h);
endinterface : ub_if

// ==== ub_dev.sv ====
// Overview of operation
// [RULE1] 8N1 characters both directions
// [RULE2] Reset baud divider gives 9600 bit/s
// [RULE3] Greeting 0x4F then 0x4B after reset
// [RULE4] Unknown command bytes silently dropped
// [RULE5] Long inter-byte gap clears partial command
// [RULE6] 0x53 starts frame, 0x50 stops it
// [RULE7] 0x52 register read, 0x57 register write
// [RULE8] 0x49 port read, 0x4F port write, 0x5A sleep
// [RULE9] Write frame: address, count, data, stop
// [RULE10] Host clears address LSB for writes
// [RULE11] Read frame: address, count, stop
// [RULE12] Host sets address LSB for reads
// [RULE13] Read count bytes, then return them
// [RULE14] Device is bus controller with arbitration
// [RULE15] Sleep sequence; wake on receive low; code wakes only once a whole character has been received
// [RULE16] Register writes as index/data pairs
// [RULE17] Register reads answer in list order
// [RULE18] Bad sleep sequence ignored; wake char dropped
// [RULE19] Start after write frame: repeated start
// [RULE20] Bus start after header, stop after frame; code starts the bus only once a stop or start code ends the frame
`timescale 1ns/1ps
module ub_dev
	import ub_pkg::*;
#(
	parameter int TIMEOUT_CYC_P = TIMEOUT_CYC,
	parameter logic [15:0] BAUD_DIV = BAUD_DIV_RST,
	parameter int QTR_CYC = I2C_QTR
)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Host link and bus
	ub_if.dev LINK,
	// Port pins
	input wire logic [7:0] GPIO_IN,
	output logic [7:0] GPIO_OUT,
	output logic [7:0] GPIO_OE
);
	localparam int TW = $clog2(TIMEOUT_CYC_P + 1);
	localparam int QW = $clog2(QTR_CYC + 1);
	typedef enum logic [2:0] {S_IDLE = 3'h0, S_START = 3'h1, S_BIT = 3'h3, S_STOP = 3'h2, S_RESP = 3'h6,
		S_SLEEP = 3'h7} ub_st_t;
	typedef enum logic [3:0] {P_CMD = 4'h0, P_ADDR = 4'h1, P_CNT = 4'h3, P_WDATA = 4'h2, P_END = 4'h6,
		P_RREG = 4'h7, P_WIDX = 4'h5, P_WVAL = 4'h4, P_GOUT = 4'hc, P_Z1 = 4'hd, P_Z2 = 4'hf, P_Z3 = 4'he} ub_ph_t;
	typedef struct packed {
		ub_st_t st;
		ub_ph_t ph;
		logic rx_busy;
		logic [15:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_vld;
		logic tx_busy;
		logic [15:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [8:0] tx_sh;
		logic txd;
		logic scl_drv;
		logic sda_drv;
		logic [QW-1:0] q;
		logic [1:0] step;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic nak;
		logic adr;
		logic rd;
		logic stop;
		logic [7:0] addr;
		logic [7:0] cnt;
		logic [7:0] idx;
		logic [TW-1:0] to;
		logic [3:0] stat;
		logic [7:0] gout;
		logic [7:0] goe;
		logic [REG_NUM-1:0][7:0] regs;
		logic [BUF_DEPTH-1:0][7:0] buff;
	} ub_dev_t;

	ub_dev_t s;
	ub_dev_t next_s;
	logic [15:0] div;
	logic [7:0] b;
	logic wrb;
	logic ob;
	logic fin;

	function automatic logic [7:0] reg_rd(input logic [7:0] i, input logic [REG_NUM-1:0][7:0] r,
		input logic [7:0] gin, input logic [3:0] st);
		logic [7:0] v;
		v = 8'h00;
		if (i == REG_IOSTATE)
			v = gin;
		else if (i == REG_STAT)
			v = {STAT_HI, st};
		else if (i < 8'(REG_NUM) && i != REG_RSVD)
			v = r[i[3:0]];
		return v;
	endfunction : reg_rd

	always_comb
	begin
		next_s = s;
		fin = 1'b0;
		b = s.rx_sh;
		// [RULE2] divider from baud registers
		div = {s.regs[REG_BAUD_DIVIDER_HI[3:0]], s.regs[REG_BAUD_DIVIDER_LO[3:0]]};
		wrb = s.adr | ~s.rd;
		ob = (s.bitn != 4'h8) ? (wrb ? s.sh[7] : 1'b1) : (wrb ? 1'b1 : (s.idx == s.cnt - 8'h1));
		next_s.rx_vld = 1'b0;
		// [RULE1] receive start, 8 data, stop
		if (!s.rx_busy)
		begin
			if (!LINK.h2d)
			begin
				next_s.rx_busy = 1'b1;
				next_s.rx_cnt = div >> 1;
				next_s.rx_bit = 4'h0;
			end
		end
		else if (s.rx_cnt != 16'h0)
			next_s.rx_cnt = s.rx_cnt - 16'h1;
		else
		begin
			next_s.rx_cnt = div - 16'h1;
			if (s.rx_bit == 4'h0 && LINK.h2d)
				next_s.rx_busy = 1'b0;
			else if (s.rx_bit < 4'h9)
			begin
				if (s.rx_bit != 4'h0)
					next_s.rx_sh = {LINK.h2d, s.rx_sh[7:1]};
				next_s.rx_bit = s.rx_bit + 4'h1;
			end
			else
			begin
				next_s.rx_busy = 1'b0;
				next_s.rx_vld = LINK.h2d;
			end
		end
		// [RULE1] transmit start, 8 data, stop
		if (s.tx_busy)
		begin
			if (s.tx_cnt != 16'h0)
				next_s.tx_cnt = s.tx_cnt - 16'h1;
			else
			begin
				next_s.tx_cnt = div - 16'h1;
				if (s.tx_bit == 4'h9)
					next_s.tx_busy = 1'b0;
				else
				begin
					next_s.txd = s.tx_sh[0];
					next_s.tx_sh = {1'b1, s.tx_sh[8:1]};
					next_s.tx_bit = s.tx_bit + 4'h1;
				end
			end
		end
		// [RULE5] gap time-out drops partial command
		if (s.rx_vld || s.st != S_IDLE || s.ph == P_CMD)
			next_s.to = '0;
		else if (s.to == TW'(TIMEOUT_CYC_P - 1))
		begin
			next_s.to = '0;
			next_s.ph = P_CMD;
		end
		else
			next_s.to = s.to + 1'b1;
		if (s.st == S_START || s.st == S_BIT || s.st == S_STOP)
		begin
			if (s.q != '0)
				next_s.q = s.q - 1'b1;
			else
				next_s.q = QW'(QTR_CYC);
		end
		case (s.st)
			S_IDLE:
			begin
				if (s.rx_vld)
				begin
					case (s.ph)
						P_CMD:
						begin
							// [RULE4] only known codes act
							case (b)
								// [RULE6] start code opens frame
								CMD_START: next_s.ph = P_ADDR;
								// [RULE7] register read and write
								CMD_RREG:
								begin
									next_s.ph = P_RREG;
									next_s.cnt = 8'h00;
								end
								CMD_WREG: next_s.ph = P_WIDX;
								// [RULE8] port read answers at once
								CMD_GPIN:
								begin
									next_s.buff[0] = GPIO_IN;
									next_s.cnt = 8'h01;
									next_s.idx = 8'h00;
									next_s.st = S_RESP;
								end
								CMD_GPOUT: next_s.ph = P_GOUT;
								CMD_SLEEP: next_s.ph = P_Z1;
								default: next_s.ph = P_CMD;
							endcase
						end
						P_ADDR:
						begin
							next_s.addr = b;
							next_s.ph = P_CNT;
						end
						P_CNT:
						begin
							next_s.cnt = b;
							next_s.idx = 8'h00;
							// [RULE11] read frame has no data bytes
							next_s.ph = (s.addr[0] || b == 8'h00) ? P_END : P_WDATA;
						end
						P_WDATA:
						begin
							// [RULE9] collect data bytes in order
							next_s.buff[s.idx] = b;
							next_s.idx = s.idx + 8'h1;
							if (s.idx == s.cnt - 8'h1)
								next_s.ph = P_END;
						end
						P_END:
						begin
							// [RULE20] bus start once stop or start code ends frame
							if (b == CMD_STOP || b == CMD_START)
							begin
								next_s.stop = (b == CMD_STOP);
								// [RULE19] chained start keeps bus
								next_s.ph = (b == CMD_STOP) ? P_CMD : P_ADDR;
								next_s.st = S_START;
								next_s.step = 2'h0;
								next_s.q = QW'(QTR_CYC);
								next_s.adr = 1'b1;
								// [RULE12] direction from address LSB
								next_s.rd = s.addr[0];
								next_s.sh = s.addr;
								next_s.bitn = 4'h0;
								next_s.idx = 8'h00;
								next_s.stat = STAT_OK;
							end
						end
						P_RREG:
						begin
							// [RULE17] one byte per index, in order
							if (b == CMD_STOP)
							begin
								next_s.ph = P_CMD;
								next_s.idx = 8'h00;
								next_s.st = S_RESP;
							end
							else
							begin
								next_s.buff[s.cnt] = reg_rd(b, s.regs, GPIO_IN, s.stat);
								next_s.cnt = s.cnt + 8'h1;
							end
						end
						P_WIDX:
						begin
							next_s.addr = b;
							next_s.ph = (b == CMD_STOP) ? P_CMD : P_WVAL;
						end
						P_WVAL:
						begin
							// [RULE16] each pair written on arrival
							if (s.addr < 8'(REG_NUM) && s.addr != REG_IOSTATE && s.addr != REG_RSVD
								&& s.addr != REG_STAT)
								next_s.regs[s.addr[3:0]] = b;
							if (s.addr == REG_IOSTATE)
								next_s.gout = b;
							next_s.ph = P_WIDX;
						end
						P_GOUT:
						begin
							next_s.gout = b;
							next_s.ph = P_CMD;
						end
						// [RULE18] mismatch abandons sleep request
						P_Z1: next_s.ph = (b == SLEEP_KEY1) ? P_Z2 : P_CMD;
						P_Z2: next_s.ph = (b == SLEEP_KEY2) ? P_Z3 : P_CMD;
						P_Z3:
						begin
							// [RULE15] enter sleep on full sequence
							next_s.ph = P_CMD;
							if (b == CMD_STOP)
								next_s.st = S_SLEEP;
						end
						default: next_s.ph = P_CMD;
					endcase
				end
			end
			S_START:
			begin
				// [RULE14] start or repeated start
				if (s.q == '0)
				begin
					case (s.step)
						2'h0: next_s.sda_drv = 1'b0;
						2'h1: next_s.scl_drv = 1'b0;
						2'h2: next_s.sda_drv = 1'b1;
						default: next_s.scl_drv = 1'b1;
					endcase
					next_s.step = s.step + 2'h1;
					if (s.step == 2'h1 && !LINK.scl)
					begin
						next_s.step = s.step;
						next_s.q = '0;
					end
					// [RULE14] bus busy elsewhere: lost
					if (s.step == 2'h2 && !LINK.sda)
					begin
						next_s.sda_drv = 1'b0;
						next_s.stat = STAT_ARB;
						next_s.st = S_IDLE;
						next_s.ph = P_CMD;
					end
					if (s.step == 2'h3)
						next_s.st = S_BIT;
				end
			end
			S_BIT:
			begin
				if (s.q == '0)
				begin
					next_s.step = s.step + 2'h1;
					case (s.step)
						2'h0: next_s.sda_drv = ~ob;
						2'h1:
						begin
							next_s.scl_drv = 1'b0;
							if (!LINK.scl)
							begin
								next_s.step = s.step;
								next_s.q = '0;
							end
						end
						2'h2:
						begin
							if (s.bitn == 4'h8)
								next_s.nak = LINK.sda;
							else
								next_s.sh = {s.sh[6:0], LINK.sda};
							// [RULE14] arbitration lost: release bus
							if (s.bitn != 4'h8 && wrb && s.sh[7] && !LINK.sda)
							begin
								next_s.scl_drv = 1'b0;
								next_s.sda_drv = 1'b0;
								next_s.stat = STAT_ARB;
								next_s.rd = 1'b0;
								next_s.st = S_IDLE;
								next_s.ph = P_CMD;
							end
						end
						default:
						begin
							next_s.scl_drv = 1'b1;
							next_s.bitn = s.bitn + 4'h1;
							if (s.bitn == 4'h8)
							begin
								next_s.bitn = 4'h0;
								if (wrb && s.nak)
								begin
									next_s.stat = s.adr ? STAT_NACK_ADR : STAT_NACK_DATA;
									next_s.rd = 1'b0;
									next_s.st = S_STOP;
								end
								else if (s.adr)
								begin
									next_s.adr = 1'b0;
									next_s.sh = s.rd ? 8'hff : s.buff[0];
									fin = (s.cnt == 8'h00);
								end
								else
								begin
									// [RULE13] store exactly count bytes
									if (s.rd)
										next_s.buff[s.idx] = s.sh;
									next_s.idx = s.idx + 8'h1;
									next_s.sh = s.rd ? 8'hff : s.buff[s.idx + 8'h1];
									fin = (s.idx == s.cnt - 8'h1);
								end
							end
						end
					endcase
				end
			end
			S_STOP:
			begin
				// [RULE20] stop releases bus after frame
				if (s.q == '0)
				begin
					next_s.step = s.step + 2'h1;
					case (s.step)
						2'h0: next_s.sda_drv = 1'b1;
						2'h1:
						begin
							next_s.scl_drv = 1'b0;
							if (!LINK.scl)
							begin
								next_s.step = s.step;
								next_s.q = '0;
							end
						end
						default:
						begin
							next_s.sda_drv = 1'b0;
							next_s.step = 2'h0;
							next_s.idx = 8'h00;
							next_s.st = s.rd ? S_RESP : S_IDLE;
						end
					endcase
				end
			end
			S_RESP:
			begin
				// [RULE3] greeting and replies from buffer
				if (!s.tx_busy)
				begin
					if (s.idx == s.cnt)
						next_s.st = S_IDLE;
					else
					begin
						next_s.tx_busy = 1'b1;
						next_s.txd = 1'b0;
						next_s.tx_sh = {1'b1, s.buff[s.idx]};
						next_s.tx_cnt = div - 16'h1;
						next_s.tx_bit = 4'h0;
						next_s.idx = s.idx + 8'h1;
					end
				end
			end
			S_SLEEP:
			begin
				// [RULE18] waking character is discarded
				if (s.rx_vld)
					next_s.st = S_IDLE;
			end
			default: next_s.st = S_IDLE;
		endcase
		if (fin)
		begin
			next_s.step = 2'h0;
			// [RULE19] no stop when next frame follows
			if (s.stop)
				next_s.st = S_STOP;
			else
			begin
				next_s.idx = 8'h00;
				next_s.st = s.rd ? S_RESP : S_IDLE;
			end
		end
		for (int i = 0; i < 8; i++)
			next_s.goe[i] = (next_s.regs[REG_PORTCFG1[3:0] + 4'(i / 4)][2 * (i % 4) +: 2] == 2'h2);
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			s <= '0;
			// [RULE3] greeting queued at reset
			s.st <= S_RESP;
			s.cnt <= 8'h02;
			s.buff[0] <= HELLO0;
			s.buff[1] <= HELLO1;
			s.txd <= 1'b1;
			// [RULE2] reset divider for 9600 bit/s
			s.regs[REG_BAUD_DIVIDER_LO[3:0]] <= BAUD_DIV[7:0];
			s.regs[REG_BAUD_DIVIDER_HI[3:0]] <= BAUD_DIV[15:8];
			s.regs[REG_PORTCFG1[3:0]] <= RST_PORTCFG;
			s.regs[REG_PORTCFG2[3:0]] <= RST_PORTCFG;
			s.regs[REG_OWNADR[3:0]] <= RST_OWNADR;
			s.regs[REG_CLKLO[3:0]] <= RST_CLKLO;
			s.regs[REG_CLKHI[3:0]] <= RST_CLKHI;
			s.regs[REG_TOUT[3:0]] <= RST_TOUT;
		end
		else
			s <= next_s;
	end

	assign LINK.d2h = s.txd;
	assign LINK.scl_o = 1'b0;
	assign LINK.sda_o = 1'b0;
	assign LINK.scl_oe = s.scl_drv;
	assign LINK.sda_oe = s.sda_drv;
	assign GPIO_OUT = s.gout;
	assign GPIO_OE = s.goe;
endmodule : ub_dev

// ==== ub_host.sv ====
`timescale 1ns/1ps
module ub_host
	import ub_pkg::*;
#(
	parameter logic [15:0] BIT_CYC = BAUD_DIV_RST,
	parameter int TIMEOUT_CYC_P = TIMEOUT_CYC
)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Link to bridge
	ub_if.host LINK,
	// Send side
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	input wire logic READ_FRAME,
	output logic TX_READY,
	// Receive side
	output logic [7:0] RX_DATA,
	output logic RX_VALID,
	output logic GAP_LATE
);
	localparam int TW = $clog2(TIMEOUT_CYC_P + 1);
	typedef enum logic [3:0] {H_CMD = 4'h0, H_ADDR = 4'h1, H_CNT = 4'h3, H_DATA = 4'h2, H_END = 4'h6,
		H_WIDX = 4'h7, H_WVAL = 4'h5, H_SKIP = 4'h4, H_RIDX = 4'hc} ub_hp_t;
	typedef struct packed {
		ub_hp_t hp;
		logic [7:0] n8;
		logic tx_busy;
		logic [15:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [8:0] tx_sh;
		logic txd;
		logic rdy;
		logic rx_busy;
		logic [15:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_vld;
		logic [TW-1:0] to;
		logic late;
	} ub_host_t;

	ub_host_t s;
	ub_host_t next_s;
	logic [7:0] b;
	logic take;

	always_comb
	begin
		next_s = s;
		take = TX_VALID & s.rdy;
		// [RULE10] write frame address LSB cleared
		// [RULE12] read frame address LSB set
		b = (s.hp == H_ADDR) ? {TX_DATA[7:1], READ_FRAME} : TX_DATA;
		next_s.rx_vld = 1'b0;
		if (s.tx_busy)
		begin
			if (s.tx_cnt != 16'h0)
				next_s.tx_cnt = s.tx_cnt - 16'h1;
			else
			begin
				next_s.tx_cnt = BIT_CYC - 16'h1;
				if (s.tx_bit == 4'h9)
					next_s.tx_busy = 1'b0;
				else
				begin
					next_s.txd = s.tx_sh[0];
					next_s.tx_sh = {1'b1, s.tx_sh[8:1]};
					next_s.tx_bit = s.tx_bit + 4'h1;
				end
			end
		end
		else if (take)
		begin
			// [RULE1] start bit, 8 data, stop bit
			next_s.tx_busy = 1'b1;
			next_s.txd = 1'b0;
			next_s.tx_sh = {1'b1, b};
			next_s.tx_cnt = BIT_CYC - 16'h1;
			next_s.tx_bit = 4'h0;
			// [RULE9] follow frame layout byte by byte
			case (s.hp)
				H_CMD:
				begin
					// [RULE6] start code opens frame
					if (b == CMD_START)
						next_s.hp = H_ADDR;
					else if (b == CMD_WREG)
						next_s.hp = H_WIDX;
					else if (b == CMD_RREG)
						next_s.hp = H_RIDX;
					else if (b == CMD_GPOUT || b == CMD_SLEEP)
					begin
						next_s.hp = H_SKIP;
						next_s.n8 = (b == CMD_SLEEP) ? 8'h02 : 8'h01;
					end
				end
				H_ADDR: next_s.hp = H_CNT;
				H_CNT:
				begin
					// [RULE11] read frame carries no data
					next_s.n8 = b;
					next_s.hp = (READ_FRAME || b == 8'h00) ? H_END : H_DATA;
				end
				H_DATA:
				begin
					next_s.n8 = s.n8 - 8'h1;
					if (s.n8 == 8'h01)
						next_s.hp = H_END;
				end
				H_END: next_s.hp = (b == CMD_START) ? H_ADDR : H_CMD;
				// [RULE16] register pairs until stop
				H_WIDX: next_s.hp = (b == CMD_STOP) ? H_CMD : H_WVAL;
				H_WVAL: next_s.hp = H_WIDX;
				// [RULE17] index list open until stop
				H_RIDX: next_s.hp = (b == CMD_STOP) ? H_CMD : H_RIDX;
				H_SKIP:
				begin
					next_s.n8 = s.n8 - 8'h1;
					if (s.n8 == 8'h01)
						next_s.hp = H_CMD;
				end
				default: next_s.hp = H_CMD;
			endcase
		end
		// [RULE5] watch gap inside an open frame
		if (take)
		begin
			next_s.to = '0;
			next_s.late = 1'b0;
		end
		else if (s.hp == H_CMD)
			next_s.to = '0;
		else if (s.to == TW'(TIMEOUT_CYC_P - 1))
		begin
			next_s.to = '0;
			next_s.hp = H_CMD;
			next_s.late = 1'b1;
		end
		else
			next_s.to = s.to + 1'b1;
		if (!s.rx_busy)
		begin
			if (!LINK.d2h)
			begin
				next_s.rx_busy = 1'b1;
				next_s.rx_cnt = BIT_CYC >> 1;
				next_s.rx_bit = 4'h0;
			end
		end
		else if (s.rx_cnt != 16'h0)
			next_s.rx_cnt = s.rx_cnt - 16'h1;
		else
		begin
			next_s.rx_cnt = BIT_CYC - 16'h1;
			if (s.rx_bit == 4'h0 && LINK.d2h)
				next_s.rx_busy = 1'b0;
			else if (s.rx_bit < 4'h9)
			begin
				if (s.rx_bit != 4'h0)
					next_s.rx_sh = {LINK.d2h, s.rx_sh[7:1]};
				next_s.rx_bit = s.rx_bit + 4'h1;
			end
			else
			begin
				next_s.rx_busy = 1'b0;
				next_s.rx_vld = LINK.d2h;
			end
		end
		next_s.rdy = ~next_s.tx_busy;
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			s <= '0;
			s.txd <= 1'b1;
			s.rdy <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign LINK.h2d = s.txd;
	assign TX_READY = s.rdy;
	assign RX_DATA = s.rx_sh;
	assign RX_VALID = s.rx_vld;
	assign GAP_LATE = s.late;
endmodule : ub_host

// ==== ub_assertions.sv ====
`timescale 1ns/1ps
module ub_assertions #(
	parameter int BIT = 16
)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Link and bus
	input wire logic h2d,
	input wire logic d2h,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic scl,
	input wire logic sda
);
	int tx_cnt;
	int rx_cnt;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// Position within a character on each line
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			tx_cnt <= 0;
			rx_cnt <= 0;
		end
		else
		begin
			tx_cnt <= (tx_cnt == 0 || tx_cnt == 10 * BIT) ? int'(!d2h) : tx_cnt + 1;
			rx_cnt <= (rx_cnt == 0 || rx_cnt == 10 * BIT) ? int'(!h2d) : rx_cnt + 1;
		end
	end
	sequence s_bus_start;
		$fell(sda) && scl;
	endsequence
	sequence s_bus_stop;
		$rose(sda) && scl && $past(scl);
	endsequence
	AST_GREET_START: assert property ($rose(RST_N) |-> ##[0:3] !d2h)
		else $error("greeting start bit missing");
	AST_RESET_QUIET: assert property ($rose(RST_N) |-> d2h && !scl_oe && !sda_oe)
		else $error("lines not idle after reset");
	AST_START_BIT: assert property (tx_cnt >= 1 && tx_cnt <= BIT - 2 |-> !d2h)
		else $error("start bit too short");
	AST_STOP_BIT: assert property (tx_cnt >= 9 * BIT + 1 && tx_cnt <= 10 * BIT - 2 |-> d2h)
		else $error("stop bit not high");
	AST_BUS_START: assert property (s_bus_start |-> sda_oe ##[1:16] !scl)
		else $error("start not followed by clock low");
	AST_BUS_STOP: assert property (s_bus_stop |-> !sda_oe && !scl_oe)
		else $error("bus not released at stop");
	AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*4])
		else $error("clock low phase too short");
	AST_SDA_STABLE: assert property (scl && $past(scl) && $changed(sda) |-> $changed(sda_oe))
		else $error("data moved while clock high");
	AST_HDR_FIRST: assert property (s_bus_start |-> rx_cnt == 0 || rx_cnt > 9 * BIT)
		else $error("bus start during host character");
endmodule : ub_assertions

// ==== ub_tb.sv ====
`timescale 1ns/1ps
module ub_tb;
	logic clk = 1'b0;
	logic rst_n;
	logic [7:0] tx_data;
	logic tx_valid;
	logic read_frame;
	logic tx_ready;
	logic [7:0] rx_data;
	logic rx_valid;
	logic gap_late;
	logic [7:0] gpio_in;
	logic [7:0] gpio_out;
	logic [7:0] gpio_oe;
	logic [7:0] sh;
	logic [7:0] rbyte = 8'h6c;
	logic [7:0] wq[$];
	logic rd;
	logic first;
	int bc;
	int starts;
	int stops;
	int fail_count = 0;
	int checks = 0;
	ub_if bus();
	ub_dev #(.TIMEOUT_CYC_P(2000), .BAUD_DIV(16'h0010), .QTR_CYC(4)) ub_dev_inst (.CLK(clk), .RST_N(rst_n),
		.LINK(bus), .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe));
	ub_host #(.BIT_CYC(16'h0010), .TIMEOUT_CYC_P(2000)) ub_host_inst (.CLK(clk), .RST_N(rst_n), .LINK(bus),
		.TX_DATA(tx_data), .TX_VALID(tx_valid), .READ_FRAME(read_frame), .TX_READY(tx_ready),
		.RX_DATA(rx_data), .RX_VALID(rx_valid), .GAP_LATE(gap_late));
	ub_assertions ub_assertions_inst (.CLK(clk), .RST_N(rst_n), .h2d(bus.h2d), .d2h(bus.d2h),
		.scl_oe(bus.scl_oe), .sda_oe(bus.sda_oe), .scl(bus.scl), .sda(bus.sda));
	always #12.5 clk = ~clk;
	// Target: acks every byte, answers reads with rbyte
	always @(negedge bus.sda)
	begin
		if (bus.scl === 1'b1)
		begin
			starts++;
			bc = -1;
			first = 1'b1;
			rd = 1'b0;
			bus.tgt_sda_oe = 1'b0;
		end
	end
	always @(posedge bus.sda)
	begin
		if (bus.scl === 1'b1)
			stops++;
	end
	always @(posedge bus.scl)
		sh = {sh[6:0], bus.sda};
	always @(negedge bus.scl)
	begin
		bc++;
		if (bc == 9)
		begin
			bc = 0;
			bus.tgt_sda_oe = rd && (first || !sh[0]) && !rbyte[7];
			first = 1'b0;
		end
		else if (rd && !first)
			bus.tgt_sda_oe = !rbyte[3'(7 - bc)] && bc < 8;
		else if (bc == 8)
		begin
			wq.push_back(sh);
			if (first)
				rd = sh[0];
			bus.tgt_sda_oe = 1'b1;
			bus.tgt_scl_oe = 1'b1;
			#387.5 bus.tgt_scl_oe = 1'b0;
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic send(input logic [7:0] b, input logic rf);
		@(negedge clk);
		tx_data = b;
		tx_valid = 1'b1;
		read_frame = rf;
		do
			@(posedge clk);
		while (tx_ready !== 1'b1);
		@(negedge clk);
		tx_valid = 1'b0;
	endtask : send
	task automatic tx(input logic [7:0] q[$], input logic rf);
		foreach (q[i])
			send(q[i], rf);
	endtask : tx
	task automatic rx(input logic [7:0] e);
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (rx_valid !== 1'b1 && n < 3000);
		check({7'h00, rx_valid}, 8'h01);
		check(rx_data, e);
	endtask : rx
	task automatic wait_bus(input int s);
		int n;
		n = 0;
		while (stops < s && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
		check(8'(stops), 8'(s));
	endtask : wait_bus
	task automatic wq_chk(input logic [7:0] e[$]);
		check(8'(wq.size()), 8'(e.size()));
		foreach (e[i])
			check(wq[i], e[i]);
		wq.delete();
	endtask : wq_chk
	task automatic end_sim;
		if (fail_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (60000) @(posedge clk);
		fail_count++;
		end_sim();
	end
	initial
	begin
		rst_n = 1'b0;
		tx_data = 8'h00;
		tx_valid = 1'b0;
		read_frame = 1'b0;
		gpio_in = 8'h96;
		bus.tgt_sda_oe = 1'b0;
		bus.tgt_scl_oe = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		starts = 0;
		stops = 0;
		rx(8'h4f);
		rx(8'h4b);
		tx('{8'h41}, 1'b0);
		tx('{8'h52, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h50}, 1'b0);
		rx(8'h26);
		rx(8'h13);
		rx(8'h66);
		rx(8'hf0);
		tx('{8'h57, 8'h06, 8'h5c, 8'h08, 8'h3a, 8'h02, 8'h56, 8'h50}, 1'b0);
		tx('{8'h52, 8'h08, 8'h06, 8'h50}, 1'b0);
		rx(8'h3a);
		rx(8'h5c);
		check(gpio_oe, 8'h01);
		tx('{8'h4f, 8'h3c, 8'h50, 8'h49}, 1'b0);
		rx(8'h96);
		check(gpio_out, 8'h3c);
		gpio_in = 8'h5b;
		tx('{8'h52, 8'h04, 8'h50}, 1'b0);
		rx(8'h5b);
		wq.delete();
		tx('{8'h53, 8'ha1, 8'h02, 8'h11, 8'h22, 8'h50}, 1'b0);
		wait_bus(1);
		wq_chk('{8'ha0, 8'h11, 8'h22});
		tx('{8'h53, 8'ha0, 8'h02, 8'h50}, 1'b1);
		rx(8'h6c);
		rx(8'h6c);
		wq_chk('{8'ha1});
		tx('{8'h52, 8'h0a, 8'h50}, 1'b0);
		rx(8'hf0);
		tx('{8'h53, 8'ha0, 8'h01, 8'h77, 8'h53}, 1'b0);
		for (int n = 0; n < 3000 && wq.size() < 2; n++)
			@(negedge clk);
		repeat (40) @(negedge clk);
		tx('{8'ha0, 8'h01, 8'h50}, 1'b1);
		rx(8'h6c);
		wait_bus(3);
		check(8'(starts), 8'h04);
		wq_chk('{8'ha0, 8'h77, 8'ha1});
		tx('{8'h52}, 1'b0);
		repeat (2400) @(negedge clk);
		check({7'h00, gap_late}, 8'h01);
		tx('{8'h07, 8'h52, 8'h09, 8'h50}, 1'b0);
		rx(8'h66);
		tx('{8'h5a, 8'h5a, 8'ha4, 8'h50, 8'h52, 8'h07, 8'h50}, 1'b0);
		rx(8'h13);
		tx('{8'h5a, 8'h5a, 8'ha5, 8'h50, 8'h52}, 1'b0);
		tx('{8'h52, 8'h06, 8'h50}, 1'b0);
		rx(8'h5c);
		end_sim();
	end
endmodule : ub_tb
